// ==== core/adcsq_defines.vh ====
// adcsq register map, fields, reset values and timing constants
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH
// =====================================================
// register indices, bus byte address is four times the index
`define ADCSQ_OFF_CLKDIV     8'hf2
`define ADCSQ_OFF_CONTROL    8'hf3
`define ADCSQ_OFF_RES_LOW    8'hf4
`define ADCSQ_OFF_RES_HIGH   8'hf5
`define ADCSQ_OFF_AUX        8'hf8
// =====================================================
// converter_control fields
`define ADCSQ_CTL_HALT       6
`define ADCSQ_CTL_POWER      5
`define ADCSQ_CTL_DONE       4
`define ADCSQ_CTL_GO         3
`define ADCSQ_CTL_SEL_HI     2
`define ADCSQ_CTL_SEL_LO     0
// aux register fields
`define ADCSQ_AUX_IRQEN      0
`define ADCSQ_AUX_X2         1
// divider field
`define ADCSQ_DIV_HI         4
`define ADCSQ_DIV_LO         0
// =====================================================
// reset values
`define ADCSQ_RST_CONTROL    8'h00
`define ADCSQ_RST_CLKDIV     5'h00
`define ADCSQ_RST_RESULT     10'h000
// =====================================================
// timing
`define ADCSQ_ZERO_DIV_STD   8'h80
`define ADCSQ_ZERO_DIV_X2    8'h40
`define ADCSQ_CONV_TICKS     4'hb
// axi responses
`define ADCSQ_RESP_OKAY      2'h0
`define ADCSQ_RESP_SLVERR    2'h2
`endif

// ==== core/adcsq_clkgen.v ====
// adcsq converter clock tick generator
`timescale 1ns/100ps
`include "adcsq_defines.vh"
module adcsq_clkgen (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       run,
    input  wire       double_speed_clocking,
    input  wire [4:0] clock_divide_value,
    output reg        tick
);
    reg  [7:0] count;
    wire [7:0] ratio;
    // =====================================================
    // ratio selection
    assign ratio = double_speed_clocking ?
        ((clock_divide_value == 5'h00) ? `ADCSQ_ZERO_DIV_X2 :
            {2'h0, clock_divide_value, 1'h0}) :               // [R07]
        ((clock_divide_value == 5'h00) ? `ADCSQ_ZERO_DIV_STD :
            {1'h0, clock_divide_value, 2'h0});                // [R06]
    // =====================================================
    // divider
    always @(posedge aclk) begin
        if (!aresetn || !run) begin
            count <= 8'h00;
            tick  <= 1'b0;
        end else if (count >= ratio - 8'h01) begin
            count <= 8'h00;
            tick  <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick  <= 1'b0;
        end
    end
endmodule // adcsq_clkgen

// ==== core/adcsq_seq.v ====
// adcsq conversion sequencer, eleven converter clock periods
`timescale 1ns/100ps
`include "adcsq_defines.vh"
module adcsq_seq (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       start,
    input  wire       tick,
    output reg        busy,
    output reg        sample_hold,
    output reg        finish
);
    localparam S_IDLE = 1'b0;
    localparam S_CONV = 1'b1;
    reg       state;
    reg [3:0] ticks;
    // =====================================================
    // sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state       <= S_IDLE;
            ticks       <= 4'h0;
            busy        <= 1'b0;
            sample_hold <= 1'b0;
            finish      <= 1'b0;
        end else begin
            finish <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start) begin
                        state       <= S_CONV;
                        ticks       <= 4'h0;
                        busy        <= 1'b1;
                        sample_hold <= 1'b1;
                    end
                end
                S_CONV: begin
                    if (tick) begin
                        sample_hold <= 1'b0;
                        if (ticks == `ADCSQ_CONV_TICKS - 4'h1) begin // [R16]
                            state  <= S_IDLE;
                            busy   <= 1'b0;
                            finish <= 1'b1;
                        end else begin
                            ticks <= ticks + 4'h1;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule // adcsq_seq

// ==== core/adcsq_top.v ====
// adcsq converter control block with axi4-lite register slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`include "adcsq_defines.vh"
// Contract
// R01 - halt flag set: processor held during conversion, peripherals run
// R02 - power bit on powers converter, off puts it in standby
// R03 - writing go starts one conversion; hardware clears go when done
// R04 - done flag sets when result ready and may request interrupt
// R05 - three-bit input select in control bits 2 to 0
// R06 - standard clocking: divide by four times value, zero gives 128
// R07 - double speed: divide by two times value, zero gives 64
// R08 - divider field bits 4 to 0; reserved upper bits
// R09 - software writes no ones into reserved bits
// R10 - high result register shows result bits 9 to 2
// R11 - low result register shows result bits 1 to 0
// R12 - control and result registers reset to zero
// R13 - input select code is plain binary, 0 to 7
// R14 - software clears done flag; clearing re-arms interrupt
// R15 - interrupt request when done set and interrupt enable set
// R16 - conversion lasts eleven converter clock periods
// R17 - results update with done set and go clear; go zero ignored
module adcsq_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [9:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [9:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [9:0]  conv_result,
    output reg         converter_power_on,
    output reg  [2:0]  input_select,
    output wire        sample_hold,
    output wire        conv_active,
    output wire        cpu_halt,
    output wire        conversion_irq
);
    // =====================================================
    // registers
    reg        quiet_conversion_halt;
    reg        conversion_done_flag;
    reg        conversion_go;
    reg [4:0]  clock_divide_value;
    reg        conversion_irq_enable;
    reg        double_speed_clocking;
    reg [9:0]  result;
    reg        aw_held;
    reg [7:0]  aw_addr;
    reg        w_held;
    reg [31:0] w_data;
    reg        w_lane0;
    wire       do_write;
    wire       start_pulse;
    wire       tick;
    wire       busy;
    wire       finish;
    wire [7:0] ctl_read;

    function addr_known;
        input [7:0] a;
        begin
            addr_known = (a == `ADCSQ_OFF_CLKDIV) || (a == `ADCSQ_OFF_CONTROL) ||
                         (a == `ADCSQ_OFF_RES_LOW) || (a == `ADCSQ_OFF_RES_HIGH) ||
                         (a == `ADCSQ_OFF_AUX);
        end
    endfunction

    // =====================================================
    // write channels, taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            aw_addr      <= 8'h00;
            w_held       <= 1'b0;
            w_data       <= 32'h00000000;
            w_lane0      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ADCSQ_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[9:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                w_data  <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_known(aw_addr) ? `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // =====================================================
    // control state
    assign start_pulse = do_write && w_lane0 && (aw_addr == `ADCSQ_OFF_CONTROL) &&
                         w_data[`ADCSQ_CTL_GO] && !conversion_go; // [R03] [R17]

    always @(posedge aclk) begin
        if (!aresetn) begin
            quiet_conversion_halt <= 1'b0;                       // [R12]
            converter_power_on    <= 1'b0;
            conversion_done_flag  <= 1'b0;
            conversion_go         <= 1'b0;
            input_select          <= 3'h0;
            clock_divide_value    <= `ADCSQ_RST_CLKDIV;
            conversion_irq_enable <= 1'b0;
            double_speed_clocking <= 1'b0;
            result                <= `ADCSQ_RST_RESULT;
        end else begin
            if (do_write && w_lane0) begin
                case (aw_addr)
                    `ADCSQ_OFF_CONTROL: begin
                        quiet_conversion_halt <= w_data[`ADCSQ_CTL_HALT];  // [R01]
                        converter_power_on    <= w_data[`ADCSQ_CTL_POWER]; // [R02]
                        input_select <= w_data[`ADCSQ_CTL_SEL_HI:`ADCSQ_CTL_SEL_LO]; // [R05] [R13]
                        if (!w_data[`ADCSQ_CTL_DONE])
                            conversion_done_flag <= 1'b0;        // [R14]
                        if (w_data[`ADCSQ_CTL_GO] && converter_power_on)
                            conversion_go <= 1'b1;               // [R03] [R02]
                    end
                    `ADCSQ_OFF_CLKDIV: begin
                        clock_divide_value <= w_data[`ADCSQ_DIV_HI:`ADCSQ_DIV_LO]; // [R08]
                    end
                    `ADCSQ_OFF_AUX: begin
                        conversion_irq_enable <= w_data[`ADCSQ_AUX_IRQEN];
                        double_speed_clocking <= w_data[`ADCSQ_AUX_X2];
                    end
                    default: begin
                    end
                endcase
            end
            if (finish) begin
                conversion_done_flag <= 1'b1;                    // [R04] [R17]
                conversion_go        <= 1'b0;                    // [R03]
                result               <= conv_result;             // [R17]
            end
        end
    end

    // =====================================================
    // converter clock and sequencer
    adcsq_clkgen u_clkgen (
        .aclk                  (aclk),
        .aresetn               (aresetn),
        .run                   (busy),
        .double_speed_clocking (double_speed_clocking),
        .clock_divide_value    (clock_divide_value),
        .tick                  (tick)
    );

    adcsq_seq u_seq (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .start       (start_pulse && converter_power_on),        // [R02]
        .tick        (tick),
        .busy        (busy),
        .sample_hold (sample_hold),
        .finish      (finish)
    );

    assign conv_active    = busy;
    assign cpu_halt       = busy && quiet_conversion_halt;       // [R01]
    assign conversion_irq = conversion_done_flag && conversion_irq_enable; // [R04] [R15]

    // =====================================================
    // read channel
    assign ctl_read = {1'b0, quiet_conversion_halt, converter_power_on,
                       conversion_done_flag, conversion_go, input_select};
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `ADCSQ_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= addr_known(s_axi_araddr[9:2]) ?
                            `ADCSQ_RESP_OKAY : `ADCSQ_RESP_SLVERR;
            case (s_axi_araddr[9:2])
                `ADCSQ_OFF_CONTROL:  s_axi_rdata <= {24'h000000, ctl_read};
                `ADCSQ_OFF_CLKDIV:   s_axi_rdata <= {27'h0000000, clock_divide_value}; // [R08]
                `ADCSQ_OFF_RES_LOW:  s_axi_rdata <= {30'h00000000, result[1:0]};      // [R11]
                `ADCSQ_OFF_RES_HIGH: s_axi_rdata <= {24'h000000, result[9:2]};        // [R10]
                `ADCSQ_OFF_AUX:      s_axi_rdata <= {30'h00000000, double_speed_clocking,
                                                     conversion_irq_enable};
                default:             s_axi_rdata <= 32'h00000000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // adcsq_top

// ==== bench/adcsq_props.sv ====
// adcsq checker on the top module ports
`timescale 1ns/100ps
module adcsq_props (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        converter_power_on,
    input wire logic [2:0]  input_select,
    input wire logic        sample_hold,
    input wire logic        conv_active,
    input wire logic        cpu_halt,
    input wire logic        conversion_irq
);
    // ====================
    // properties
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    halt_in_conv_a: assert property (cpu_halt |-> conv_active)
        else $error("halt outside conversion");
    power_in_conv_a: assert property (conv_active |-> converter_power_on)
        else $error("conversion without power");
    start_samples_a: assert property ($rose(conv_active) |-> sample_hold)
        else $error("no sample phase at start");
    sample_in_conv_a: assert property (sample_hold |-> conv_active)
        else $error("sample outside conversion");
    bits_phase_a: assert property ($fell(sample_hold) && conv_active |=> conv_active [*8])
        else $error("bit phase too short");
    irq_after_conv_a: assert property ($rose(conversion_irq) |-> !conv_active)
        else $error("irq during conversion");
    reset_zero_a: assert property (disable iff (1'b0) !aresetn |=> !conv_active &&
        !conversion_irq && !converter_power_on && input_select == 3'h0)
        else $error("outputs not cleared by reset");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
endmodule // adcsq_props
bind adcsq_top adcsq_props adcsq_props_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .converter_power_on(converter_power_on), .input_select(input_select),
    .sample_hold(sample_hold), .conv_active(conv_active), .cpu_halt(cpu_halt),
    .conversion_irq(conversion_irq));

// ==== bench/adcsq_core_model.sv ====
// adcsq analog core model with sample and hold
`timescale 1ns/100ps
module adcsq_core_model (
    input  wire logic       aclk,
    input  wire logic       converter_power_on,
    input  wire logic [2:0] input_select,
    input  wire logic       sample_hold,
    output logic      [9:0] conv_result
);
    // ====================
    // channel value held at sample phase
    logic [9:0] held = 10'h000;
    always @(posedge aclk) begin
        if (sample_hold) begin
            held <= {input_select, 7'h35};
        end
    end
    assign conv_result = converter_power_on ? held : ~held;
endmodule // adcsq_core_model

// ==== bench/tb_adcsq_top.sv ====
// adcsq testbench: axi register accesses and conversions
`timescale 1ns/100ps
module tb_adcsq_top;
    logic aclk = 0, aresetn = 0;
    logic [9:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, pwr, shold, act, halt, irq;
    logic [1:0] bresp, rresp;
    logic [2:0] sel;
    logic [9:0] res;
    int errors = 0, checks_done = 0, act_n = 0, last_n = 0, r, dv;
    // ====================
    // design and partner
    adcsq_top adcsq_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .conv_result(res), .converter_power_on(pwr),
        .input_select(sel), .sample_hold(shold), .conv_active(act), .cpu_halt(halt),
        .conversion_irq(irq));
    adcsq_core_model adcsq_core_model_i (.aclk(aclk), .converter_power_on(pwr),
        .input_select(sel), .sample_hold(shold), .conv_result(res));
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) begin
        if (act) act_n <= act_n + 1;
        else if (act_n != 0) begin
            last_n <= act_n;
            act_n <= 0;
        end
    end
    // ====================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= {a, 2'h0}; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        chk(bresp, 2'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs);
        @(posedge aclk);
        araddr <= {a, 2'h0}; arvalid <= 1; rready <= 1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        chk(rdata, {24'h0, d});
        chk(rresp, rs);
    endtask
    task automatic finish_test;
        if (errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ====================
    // tests
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 4; i++) rd(8'hf2 + i[7:0], 8'h00, 2'h0);
        rd(8'h00, 8'h00, 2'h2);
        wr(8'hf2, 8'h1f);
        rd(8'hf2, 8'h1f, 2'h0);
        wr(8'hf3, 8'h20);
        chk(pwr, 1);
        for (int k = 0; k < 8; k++) begin
            dv = (k == 2 || k == 3) ? 0 : k;
            r = dv == 0 ? (k[0] ? 64 : 128) : (k[0] ? 2 : 4) * dv;
            wr(8'hf8, {6'h0, k[0], k[1]});
            rd(8'hf8, {6'h0, k[0], k[1]}, 2'h0);
            wr(8'hf2, dv[7:0]);
            wr(8'hf3, {1'b0, k[2], 3'h5, k[2:0]});
            chk(halt, k[2]);
            chk(sel, k[2:0]);
            for (int t = 0; t < 2000 && act; t++) @(posedge aclk);
            rd(8'hf3, {1'b0, k[2], 3'h6, k[2:0]}, 2'h0);
            chk(32'(last_n >= 10 * r + 1 && last_n <= 11 * r + 1), 1);
            chk(irq, k[1]);
            rd(8'hf5, {k[2:0], 5'h0d}, 2'h0);
            rd(8'hf4, 8'h01, 2'h0);
            wr(8'hf3, 8'h20);
            chk(irq, 0);
            rd(8'hf3, 8'h20, 2'h0);
        end
        wr(8'hf3, 8'h00);
        chk(pwr, 0);
        wr(8'hf3, 8'h08);
        chk(act, 0);
        rd(8'hf3, 8'h00, 2'h0);
        finish_test;
    end
    initial begin
        #(50 * 30000);
        errors++;
        finish_test;
    end
endmodule // tb_adcsq_top
